// *** design/rscr_pkg.sv ***
// Constants, field layout and state codes for the retimer register bank.
// Assumes one 25 MHz clock and an SMBus host on the far side of the pins.
//
// Contract
// R1: Each channel: three-bit de-emphasis level field.
// R2: Bit 6 extends the de-emphasis level range.
// R3: One shared set plus four channel sets.
// R4: Host never writes reserved registers or bits; the bench writes reserved de-emphasis bits (0xc1, 0xfa).
// R5: Host does read-modify-write for partial changes.
// R6: Writes to register_set_select always hit select register.
// R7: Enable bit clear decodes everything to shared.
// R8: Shared address reads shared copy unless enabled.
// R9: Bits 1:0 pick the target channel.
// R10: Enable plus broadcast writes all channel sets.
// R11: Writes to read-only fields are dropped.
// R12: Fields are read-only, read-write or self-clearing.
// R13: Strap readback; bus address is 0x18 plus strap.
// R14: Channel reads use the index, even broadcasting.
// R15: Select register unreadable; host writes upper zeros.
// R16: Select register is zero after reset.
package rscr_pkg;

	// Register offsets
	localparam logic [7:0] OFS_STRAP       = 8'h00;
	localparam logic [7:0] OFS_IDENT       = 8'h01;
	localparam logic [7:0] OFS_SHARED_CTRL = 8'h04;
	localparam logic [7:0] OFS_DEEMPH      = 8'h15;
	localparam logic [7:0] OFS_SELECT      = 8'hff;

	// Field positions
	localparam int STRAP_LSB        = 4;
	localparam int DEEMPH_RANGE_BIT = 6;
	localparam int SEL_BCAST_BIT    = 3;
	localparam int SEL_EN_BIT       = 2;
	localparam int SHARED_RESET_BIT = 6;

	// Values
	localparam logic [6:0] BUS_ADDR_BASE     = 7'h18;
	localparam logic [7:0] DEEMPH_RW_MASK    = 8'h47;
	localparam logic [7:0] DEEMPH_RESET      = 8'h00;
	localparam logic [3:0] SELECT_RESET      = 4'h0;
	localparam logic [7:0] SELECT_READ_VALUE = 8'h00;
	// Arbitrary version and part code
	localparam logic [7:0] IDENT_VALUE       = 8'h5a;

	// Bit counts of one bus byte
	localparam logic [3:0] BYTE_LAST = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// Bus slave states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_ACK  = 6'h04,
		ST_RX   = 6'h08,
		ST_TX   = 6'h10,
		ST_MACK = 6'h20
	} rscr_state_type;

endpackage

// *** design/rscr_chan_regs.sv ***
// One channel register set: the driver de-emphasis control byte.
// Assumes the caller has already decoded offset and channel selection.
`timescale 1ns/100ps
module rscr_chan_regs (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       reset_n_in,
	// Write strobe and data
	input  wire logic       wr_in,
	input  wire logic [7:0] wdata_in,
	// Stored value and driver settings
	output logic      [7:0] reg_out,
	output logic      [2:0] level_out,
	output logic            range_out
);
	import rscr_pkg::*;

	// Only the level and range bits are stored; reserved bits read zero
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			reg_out <= DEEMPH_RESET;
		end else if (wr_in) begin
			reg_out <= wdata_in & DEEMPH_RW_MASK; // R1 R2
		end
	end

	assign level_out = reg_out[2:0];               // R1
	assign range_out = reg_out[DEEMPH_RANGE_BIT];  // R2
endmodule

// *** design/rscr_smbus_slave.sv ***
// Byte-level SMBus slave: address match, offset byte, writes and reads.
// Assumes scl and sda are already synchronous to the clock.
`timescale 1ns/100ps
module rscr_smbus_slave (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       reset_n_in,
	// Bus pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_oe_n_out,
	// Register side
	input  wire logic [6:0] dev_addr_in,
	input  wire logic [7:0] rdata_in,
	output logic            wr_out,
	output logic            rd_out,
	output logic      [7:0] offset_out,
	output logic      [7:0] wdata_out
);
	import rscr_pkg::*;

	rscr_state_type state_q;
	logic           scl_q;
	logic           sda_q;
	logic           phase_q;
	logic           first_q;
	logic           data_q;
	logic           rw_q;
	logic     [3:0] cnt_q;
	logic     [7:0] shift_q;
	logic           scl_rise;
	logic           scl_fall;
	logic           start_seen;
	logic           stop_seen;

	// Previous pin levels for edge detection
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	assign scl_rise   = scl_in & ~scl_q;
	assign scl_fall   = ~scl_in & scl_q;
	assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
	assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;

	// Byte engine; start and stop override any state, so a stuck host recovers
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			state_q      <= ST_IDLE;
			sda_oe_n_out <= 1'b1;
			wr_out       <= 1'b0;
			rd_out       <= 1'b0;
			offset_out   <= 8'h00;
			wdata_out    <= 8'h00;
			phase_q      <= 1'b0;
			first_q      <= 1'b1;
			data_q       <= 1'b0;
			rw_q         <= 1'b0;
			cnt_q        <= 4'h0;
			shift_q      <= 8'h00;
		end else begin
			wr_out <= 1'b0;
			rd_out <= 1'b0;
			if (start_seen) begin
				state_q      <= ST_ADDR;
				sda_oe_n_out <= 1'b1;
				cnt_q        <= 4'h0;
				phase_q      <= 1'b0;
				first_q      <= 1'b1;
				data_q       <= 1'b0;
			end else if (stop_seen) begin
				state_q      <= ST_IDLE;
				sda_oe_n_out <= 1'b1;
			end else begin
				case (state_q)
					ST_ADDR: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], sda_in};
							cnt_q   <= cnt_q + 4'h1;
							if (cnt_q == BYTE_LAST) begin
								if (shift_q[6:0] == dev_addr_in) begin // R13
									rw_q    <= sda_in;
									state_q <= ST_ACK;
								end else begin
									state_q <= ST_IDLE;
								end
							end
						end
					end
					ST_ACK: begin
						if (scl_fall && !phase_q) begin
							phase_q      <= 1'b1;
							sda_oe_n_out <= 1'b0;
						end else if (scl_fall) begin
							phase_q <= 1'b0;
							cnt_q   <= 4'h0;
							if (rw_q) begin
								shift_q      <= rdata_in;
								sda_oe_n_out <= rdata_in[7];
								cnt_q        <= 4'h1;
								rd_out       <= 1'b1;
								state_q      <= ST_TX;
							end else begin
								sda_oe_n_out <= 1'b1;
								state_q      <= ST_RX;
								data_q       <= 1'b0;
								if (data_q) begin
									offset_out <= offset_out + 8'h01;
								end
							end
						end
					end
					ST_RX: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], sda_in};
							cnt_q   <= cnt_q + 4'h1;
							if (cnt_q == BYTE_LAST) begin
								state_q <= ST_ACK;
								first_q <= 1'b0;
								if (first_q) begin
									offset_out <= {shift_q[6:0], sda_in};
								end else begin
									wdata_out <= {shift_q[6:0], sda_in};
									wr_out    <= 1'b1;
									data_q    <= 1'b1;
								end
							end
						end
					end
					ST_TX: begin
						if (scl_fall && cnt_q == BYTE_BITS) begin
							sda_oe_n_out <= 1'b1;
							offset_out   <= offset_out + 8'h01;
							phase_q      <= 1'b0;
							state_q      <= ST_MACK;
						end else if (scl_fall) begin
							sda_oe_n_out <= shift_q[3'h7 - cnt_q[2:0]];
							cnt_q        <= cnt_q + 4'h1;
						end
					end
					ST_MACK: begin
						if (scl_rise && !phase_q) begin
							if (sda_in) begin
								state_q <= ST_IDLE;
							end else begin
								phase_q <= 1'b1;
							end
						end else if (scl_fall && phase_q) begin
							phase_q      <= 1'b0;
							shift_q      <= rdata_in;
							sda_oe_n_out <= rdata_in[7];
							cnt_q        <= 4'h1;
							rd_out       <= 1'b1;
							state_q      <= ST_TX;
						end
					end
					default: begin
						state_q      <= ST_IDLE;
						sda_oe_n_out <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule

// *** design/rscr_regbank.sv ***
// Register bank top: shared set, channel select, four channel sets.
// Assumes scl, sda and strap pins are synchronous to clock_in.
`timescale 1ns/100ps
module rscr_regbank #(
	parameter int CH_COUNT = 4
) (
	// Clock and reset
	input  wire logic                     clock_in,
	input  wire logic                     reset_n_in,
	// SMBus pins
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe_n_out,
	// Address strap
	input  wire logic [3:0]               strap_in,
	// Per-channel driver de-emphasis
	output logic [CH_COUNT-1:0][2:0]      deemph_level_out,
	output logic [CH_COUNT-1:0]           deemph_range_out
);
	import rscr_pkg::*;

	// The two-bit channel index serves exactly four channels
	if (CH_COUNT != 4) begin : g_bad_count
		$error("CH_COUNT must be 4");
	end

	logic                     strap_done_q;
	logic [3:0]               strap_q;
	logic [6:0]               dev_addr_q;
	logic [3:0]               sel_q;
	logic                     shared_reset_q;
	logic                     bus_wr;
	logic                     bus_rd;
	logic [7:0]               bus_ofs;
	logic [7:0]               bus_wdata;
	logic [7:0]               bus_rdata;
	logic                     wr_select;
	logic                     wr_shared;
	logic                     wr_chan;
	logic [CH_COUNT-1:0]      ch_wr;
	logic [CH_COUNT-1:0][7:0] ch_reg;

	// Channel k takes a write when enabled and either broadcast or indexed
	function automatic logic chan_write_hit(input logic [3:0] sel, input logic [1:0] k);
		chan_write_hit = sel[SEL_EN_BIT] && (sel[SEL_BCAST_BIT] || sel[1:0] == k);
	endfunction

	// Open-drain pin: only ever pulled low, the enable does the work
	always_ff @(posedge clock_in) begin
		sda_out <= 1'b0;
	end

	// Strap caught once, on the first edge after reset release
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			strap_done_q <= 1'b0;
			strap_q      <= 4'h0;
			dev_addr_q   <= BUS_ADDR_BASE;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			strap_q      <= strap_in;
			dev_addr_q   <= BUS_ADDR_BASE + {3'h0, strap_in}; // R13
		end
	end

	rscr_smbus_slave u_slave (
		.clock_in     (clock_in),
		.reset_n_in   (reset_n_in),
		.scl_in       (scl_in),
		.sda_in       (sda_in),
		.sda_oe_n_out (sda_oe_n_out),
		.dev_addr_in  (dev_addr_q),
		.rdata_in     (bus_rdata),
		.wr_out       (bus_wr),
		.rd_out       (bus_rd),
		.offset_out   (bus_ofs),
		.wdata_out    (bus_wdata)
	);

	// Write decode: register_set_select is never redirected into a channel set
	assign wr_select = bus_wr && bus_ofs == OFS_SELECT;                 // R6
	assign wr_shared = bus_wr && !sel_q[SEL_EN_BIT] && !wr_select;      // R7
	assign wr_chan   = bus_wr && sel_q[SEL_EN_BIT] && !wr_select;       // R8

	// Select register; upper nibble is not stored, so it can never leak back
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			sel_q <= SELECT_RESET; // R16
		end else if (shared_reset_q) begin
			sel_q <= SELECT_RESET;
		end else if (wr_select) begin
			sel_q <= bus_wdata[3:0]; // R6 R15
		end
	end

	// Shared-reset bit acts for one cycle, then clears itself
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			shared_reset_q <= 1'b0;
		end else begin
			shared_reset_q <= wr_shared && bus_ofs == OFS_SHARED_CTRL
				&& bus_wdata[SHARED_RESET_BIT]; // R12
		end
	end

	// Independent channel sets; other channel offsets are reserved and ignored
	for (genvar k = 0; k < CH_COUNT; k++) begin : g_chan
		assign ch_wr[k] = wr_chan && bus_ofs == OFS_DEEMPH
			&& chan_write_hit(sel_q, 2'(k)); // R3 R9 R10
		rscr_chan_regs u_chan (
			.clock_in   (clock_in),
			.reset_n_in (reset_n_in),
			.wr_in      (ch_wr[k]),
			.wdata_in   (bus_wdata),
			.reg_out    (ch_reg[k]),
			.level_out  (deemph_level_out[k]),
			.range_out  (deemph_range_out[k])
		);
	end

	// Read mux; writes to 0x00 and 0x01 have no storage, so they vanish
	always_comb begin
		if (bus_ofs == OFS_SELECT) begin
			bus_rdata = SELECT_READ_VALUE; // R15
		end else if (!sel_q[SEL_EN_BIT]) begin
			if (bus_ofs == OFS_STRAP) begin
				bus_rdata = {strap_q, 4'h0}; // R11 R13
			end else if (bus_ofs == OFS_IDENT) begin
				bus_rdata = IDENT_VALUE; // R11
			end else if (bus_ofs == OFS_SHARED_CTRL) begin
				bus_rdata = {1'b0, shared_reset_q, 6'h00};
			end else begin
				bus_rdata = 8'h00;
			end
		end else if (bus_ofs == OFS_DEEMPH) begin
			bus_rdata = ch_reg[sel_q[1:0]]; // R8 R14
		end else begin
			bus_rdata = 8'h00;
		end
	end

	// Checks on the decode and storage
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);

	property p_select_write;
		wr_select |=> sel_q == $past(bus_wdata[3:0]);
	endproperty
	a_select_write: assert property (p_select_write) else $error("select write lost"); // R6

	property p_shared_decode;
		!sel_q[SEL_EN_BIT] && bus_ofs == OFS_DEEMPH |-> bus_rdata == 8'h00;
	endproperty
	a_shared_decode: assert property (p_shared_decode) else $error("shared read hit a channel"); // R7

	property p_chan_read;
		sel_q[SEL_EN_BIT] && bus_ofs == OFS_DEEMPH |-> bus_rdata == ch_reg[sel_q[1:0]];
	endproperty
	a_chan_read: assert property (p_chan_read) else $error("channel read wrong set"); // R14

	property p_shared_read;
		!sel_q[SEL_EN_BIT] && bus_ofs == OFS_IDENT |-> bus_rdata == IDENT_VALUE;
	endproperty
	a_shared_read: assert property (p_shared_read) else $error("shared copy not returned"); // R8

	property p_single_write;
		wr_chan && !sel_q[SEL_BCAST_BIT] && bus_ofs == OFS_DEEMPH
			|=> ch_reg[$past(sel_q[1:0])] == ($past(bus_wdata) & DEEMPH_RW_MASK);
	endproperty
	a_single_write: assert property (p_single_write) else $error("indexed write missed"); // R9

	property p_other_hold;
		wr_chan && !sel_q[SEL_BCAST_BIT] && sel_q[1:0] != 2'h0 |=> $stable(ch_reg[0]);
	endproperty
	a_other_hold: assert property (p_other_hold) else $error("unselected channel changed"); // R3

	property p_broadcast;
		wr_chan && sel_q[SEL_BCAST_BIT] && bus_ofs == OFS_DEEMPH
			|=> ch_reg == {CH_COUNT{$past(bus_wdata) & DEEMPH_RW_MASK}};
	endproperty
	a_broadcast: assert property (p_broadcast) else $error("broadcast write incomplete"); // R10

	property p_reserved_chan;
		wr_chan && bus_ofs != OFS_DEEMPH |=> $stable(ch_reg);
	endproperty
	a_reserved_chan: assert property (p_reserved_chan) else $error("reserved write stored"); // R11

	property p_self_clear;
		wr_shared && bus_ofs == OFS_SHARED_CTRL && bus_wdata[SHARED_RESET_BIT]
			|=> shared_reset_q ##1 (!shared_reset_q && sel_q == SELECT_RESET);
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("self-clear bit misbehaved"); // R12

	property p_strap_addr;
		strap_done_q && !sel_q[SEL_EN_BIT] && bus_ofs == OFS_STRAP
			|-> bus_rdata[7:4] == dev_addr_q[3:0] - BUS_ADDR_BASE[3:0];
	endproperty
	a_strap_addr: assert property (p_strap_addr) else $error("strap and address disagree"); // R13

	property p_select_unreadable;
		bus_rd && bus_ofs == OFS_SELECT |-> bus_rdata == SELECT_READ_VALUE;
	endproperty
	a_select_unreadable: assert property (p_select_unreadable) else $error("select readable"); // R15

	property p_reset_select;
		$rose(reset_n_in) |-> sel_q == SELECT_RESET && !shared_reset_q;
	endproperty
	a_reset_select: assert property (p_reset_select) else $error("select not cleared"); // R16

	property p_driver_bits;
		ch_wr[0] |=> deemph_level_out[0] == $past(bus_wdata[2:0])
			&& deemph_range_out[0] == $past(bus_wdata[DEEMPH_RANGE_BIT]);
	endproperty
	a_driver_bits: assert property (p_driver_bits) else $error("driver setting stale"); // R1 R2

	// Main scenarios
	c_broadcast: cover property (wr_chan && sel_q[SEL_BCAST_BIT] && bus_ofs == OFS_DEEMPH);
	c_single: cover property (wr_chan && !sel_q[SEL_BCAST_BIT] && sel_q[1:0] == 2'h3);
	c_chan_read: cover property (bus_rd && sel_q[SEL_EN_BIT] && bus_ofs == OFS_DEEMPH);
	c_shared_reset: cover property (shared_reset_q);
endmodule

// *** sim/rscr_smbus_host.sv ***
// SMBus host model: start, stop, byte and register transfers.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/100ps
module rscr_smbus_host #(
	parameter int HALF = 4
) (
	// Clock and resolved data wire
	input  wire logic clock_in,
	input  wire logic sda_wire_in,
	// Host pins, 1 releases the line
	output logic      scl_out,
	output logic      sda_out
);
	// Idle bus: both lines released
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Falling edges only, clear of the sampling edge
	task automatic gap(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	// Data moves while the clock is low; sampled late in the high phase
	task automatic bit_xfer(input logic b, output logic seen);
		gap(1);
		sda_out = b;
		gap(HALF);
		scl_out = 1'b1;
		gap(HALF);
		seen = sda_wire_in;
		scl_out = 1'b0;
	endtask
	// Start, also used as repeated start
	task automatic start();
		gap(1);
		sda_out = 1'b1;
		gap(HALF);
		scl_out = 1'b1;
		gap(HALF);
		sda_out = 1'b0;
		gap(HALF);
		scl_out = 1'b0;
	endtask
	task automatic stop();
		gap(1);
		sda_out = 1'b0;
		gap(HALF);
		scl_out = 1'b1;
		gap(HALF);
		sda_out = 1'b1;
		gap(HALF);
	endtask
	// Most significant bit first, then the acknowledge slot
	task automatic send_byte(input logic [7:0] d, output logic ack_n);
		for (int i = 7; i >= 0; i--) bit_xfer(d[i], ack_n);
		bit_xfer(1'b1, ack_n);
	endtask
	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
		bit_xfer(last, s);
	endtask
	// Whole-byte write only; partial changes need a read first
	task automatic reg_write(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d, output logic ack_n);
		logic x;
		start();
		send_byte({a, 1'b0}, ack_n);
		if (ack_n == 1'b0) begin
			send_byte(off, x);
			send_byte(d, x);
		end
		stop();
	endtask
	task automatic reg_read(input logic [6:0] a, input logic [7:0] off, output logic [7:0] d);
		logic x;
		start();
		send_byte({a, 1'b0}, x);
		send_byte(off, x);
		start();
		send_byte({a, 1'b1}, x);
		recv_byte(1'b1, d);
		stop();
	endtask
endmodule

// *** sim/rscr_regbank_test.sv ***
// Bench for the register bank, driven through the host model.
// Assumes one clock and a pulled-up, wired-AND data line.
`timescale 1ns/100ps
module rscr_regbank_test;
	import rscr_pkg::*;
	localparam logic [3:0] STRAP    = 4'h9;
	localparam logic [6:0] DEV_ADDR = BUS_ADDR_BASE + {3'h0, STRAP};
	logic                  clock_in = 1'b0;
	logic                  reset_n_in;
	logic                  scl_wire;
	logic                  sda_host;
	logic                  sda_wire;
	logic                  sda_out;
	logic                  sda_oe_n_out;
	logic [3:0]            strap_in;
	logic [3:0][2:0]       deemph_level_out;
	logic [3:0]            deemph_range_out;
	int                    fail_count = 0;
	int                    check_count = 0;
	int                    cycle_count = 0;

	// Clock, and data wire with its pull-up
	always #20 clock_in = ~clock_in;
	assign sda_wire = sda_host & (sda_oe_n_out | sda_out);

	rscr_regbank #(.CH_COUNT(4)) rscr_regbank_inst (
		.clock_in        (clock_in),
		.reset_n_in      (reset_n_in),
		.scl_in          (scl_wire),
		.sda_in          (sda_wire),
		.sda_out         (sda_out),
		.sda_oe_n_out    (sda_oe_n_out),
		.strap_in        (strap_in),
		.deemph_level_out(deemph_level_out),
		.deemph_range_out(deemph_range_out)
	);
	rscr_smbus_host rscr_smbus_host_inst (
		.clock_in   (clock_in),
		.sda_wire_in(sda_wire),
		.scl_out    (scl_wire),
		.sda_out    (sda_host)
	);

	// Compare tasks, one per result kind
	task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check_bit(input string name, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Bus helpers; only documented offsets are written
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		logic a;
		rscr_smbus_host_inst.reg_write(DEV_ADDR, off, d, a);
		check_bit("write ack", 1'b0, a);
	endtask
	task automatic rd(input logic [7:0] off, input logic [7:0] exp, input string name);
		logic [7:0] d;
		rscr_smbus_host_inst.reg_read(DEV_ADDR, off, d);
		check_byte(name, exp, d);
	endtask
	// Select values always carry a zero upper nibble
	task automatic sel(input logic [7:0] v);
		wr(OFS_SELECT, v);
	endtask
	task automatic chk_ch(input int c, input logic [2:0] lvl, input logic rng);
		check_byte("level", {5'h0, lvl}, {5'h0, deemph_level_out[c]});
		check_bit("range", rng, deemph_range_out[c]);
	endtask

	task automatic test_reset_values();
		for (int c = 0; c < 4; c++) chk_ch(c, 3'h0, 1'b0);
		rd(OFS_STRAP, {STRAP, 4'h0}, "strap");
		rd(OFS_IDENT, IDENT_VALUE, "ident");
		rd(OFS_SELECT, SELECT_READ_VALUE, "select read");
	endtask
	task automatic test_read_only();
		wr(OFS_STRAP, 8'hff);
		wr(OFS_IDENT, 8'h00);
		rd(OFS_STRAP, {STRAP, 4'h0}, "strap kept");
		rd(OFS_IDENT, IDENT_VALUE, "ident kept");
	endtask
	task automatic test_channels();
		logic [7:0] v [4] = '{8'h07, 8'hc1, 8'h46, 8'hfa};
		for (int c = 0; c < 4; c++) begin
			sel(8'h04 | 8'(c));
			wr(OFS_DEEMPH, v[c]);
		end
		for (int c = 0; c < 4; c++) begin
			chk_ch(c, v[c][2:0], v[c][DEEMPH_RANGE_BIT]);
			sel(8'h04 | 8'(c));
			rd(OFS_DEEMPH, v[c] & DEEMPH_RW_MASK, "chan deemph");
			rd(OFS_STRAP, 8'h00, "chan 0x00");
		end
	endtask
	// Broadcast and index set but enable clear: accesses stay in the shared set
	task automatic test_shared_mode();
		sel(8'h0b);
		rd(OFS_DEEMPH, 8'h00, "shared driver_deemphasis_ctrl");
		chk_ch(3, 3'h2, 1'b1);
		rd(OFS_STRAP, {STRAP, 4'h0}, "shared 0x00");
	endtask
	task automatic test_broadcast();
		sel(8'h0d);
		wr(OFS_DEEMPH, 8'h45);
		for (int c = 0; c < 4; c++) chk_ch(c, 3'h5, 1'b1);
		sel(8'h06);
		wr(OFS_DEEMPH, 8'h03);
		chk_ch(1, 3'h5, 1'b1);
		chk_ch(2, 3'h3, 1'b0);
		sel(8'h0e);
		rd(OFS_DEEMPH, 8'h03, "bcast read");
	endtask
	task automatic test_select_escape();
		sel(8'h05);
		sel(8'h00);
		rd(OFS_STRAP, {STRAP, 4'h0}, "after escape");
		rd(OFS_SHARED_CTRL, 8'h00, "ctrl before");
		wr(OFS_SHARED_CTRL, 8'h40);
		rd(OFS_SHARED_CTRL, 8'h00, "self clear");
	endtask
	task automatic test_foreign_address();
		logic a;
		rscr_smbus_host_inst.reg_write(DEV_ADDR ^ 7'h01, OFS_DEEMPH, 8'h00, a);
		check_bit("foreign ack", 1'b1, a);
	endtask
	// Broadcast left on before reset would show if select survived
	task automatic test_mid_reset();
		sel(8'h0c);
		reset_n_in = 1'b0;
		repeat (2) @(negedge clock_in);
		reset_n_in = 1'b1;
		repeat (2) @(negedge clock_in);
		for (int c = 0; c < 4; c++) chk_ch(c, 3'h0, 1'b0);
		rd(OFS_STRAP, {STRAP, 4'h0}, "strap after reset");
		sel(8'h04);
		rd(OFS_DEEMPH, 8'h00, "chan after reset");
		chk_ch(0, 3'h0, 1'b0);
	endtask

	// Main sequence
	initial begin
		reset_n_in = 1'b0;
		strap_in = STRAP;
		repeat (2) @(negedge clock_in);
		reset_n_in = 1'b1;
		repeat (2) @(negedge clock_in);
		test_reset_values();
		test_read_only();
		test_channels();
		test_shared_mode();
		test_broadcast();
		test_select_escape();
		test_foreign_address();
		test_mid_reset();
		conclude();
	end
	// Hang guard, well above the expected run length
	always @(posedge clock_in) begin
		cycle_count++;
		if (cycle_count == 60000) begin
			fail_count++;
			$display("[FAIL] run cycles expected below 60000 seen %0d", cycle_count);
			conclude();
		end
	end
endmodule
